// >>> light_threshold_interrupt_status_test.sv
// Testbench: register access and interrupt status scenarios
`timescale 1ns/1ps
module light_threshold_interrupt_status_test;
	import ltis_pkg::*;
	logic        clk_sys;
	logic        rst_b;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        sample_vld;
	logic [71:0] accum_data;
	logic        saturation_evt;
	logic        fifo_level_met;
	logic        system_evt;
	logic        irq_pin;
	int          num_errors;
	int          compares;
	int          cycles;
	localparam logic [71:0] LO  = 72'h000000_000080_FFFFFF;
	localparam logic [71:0] MID = 72'h000000_000180_FFFFFF;
	localparam logic [71:0] HI  = 72'h000000_000300_000000;
	ltis_top uut (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .sample_vld(sample_vld), .accum_data(accum_data),
		.saturation_evt(saturation_evt), .fifo_level_met(fifo_level_met), .system_evt(system_evt),
		.irq_pin(irq_pin));
	ltis_meas_model meas (.clk_sys(clk_sys), .sample_vld(sample_vld), .accum_data(accum_data),
		.saturation_evt(saturation_evt), .fifo_level_met(fifo_level_met), .system_evt(system_evt));
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic tally_and_finish;
		if (num_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			tally_and_finish;
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wait_rdy;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1)
			@(posedge clk_sys);
	endtask : wait_rdy
	// Single word transfer: address phase, then data phase
	task automatic bus(input logic [7:0] ix, input logic wr, input logic [31:0] wd, output logic [31:0] rv);
		@(posedge clk_sys);
		hsel   <= 1'b1;
		htrans <= LTIS_HTRANS_NONSEQ;
		haddr  <= {22'h0, ix, 2'b00};
		hwrite <= wr;
		wait_rdy;
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy;
		rv = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] ix, input logic [31:0] d);
		logic [31:0] v;
		bus(ix, 1'b1, d, v);
	endtask : wr
	task automatic rd_chk(input logic [7:0] ix, input logic [31:0] exp);
		logic [31:0] v;
		bus(ix, 1'b0, 32'h0, v);
		check(v, exp);
	endtask : rd_chk
	task automatic set_thr(input logic [47:0] t, input logic chk);
		for (int i = 0; i < 6; i++)
		begin
			if (chk)
				rd_chk(LTIS_IDX_LOW0 + 8'(i), {24'h0, t[8*i+:8]});
			else
				wr(LTIS_IDX_LOW0 + 8'(i), {24'h0, t[8*i+:8]});
		end
	endtask : set_thr
	initial
	begin
		num_errors = 0;
		compares   = 0;
		cycles     = 0;
		rst_b      = 1'b0;
		hsel       = 1'b0;
		haddr      = 32'h0;
		htrans     = 2'h0;
		hwrite     = 1'b0;
		hsize      = 3'h2;
		hwdata     = 32'h0;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		set_thr(48'h0, 1'b1);
		rd_chk(LTIS_IDX_AUX, {28'h0, LTIS_AUX_CODE});
		rd_chk(LTIS_IDX_REV, {24'h0, LTIS_REV_CODE});
		rd_chk(LTIS_IDX_DEV, {24'h0, LTIS_DEV_CODE});
		rd_chk(LTIS_IDX_STAT, 32'h0);
		check({31'h0, irq_pin}, 32'h0);
		wr(LTIS_IDX_DEV, 32'h0000_00FF);
		rd_chk(LTIS_IDX_DEV, {24'h0, LTIS_DEV_CODE});
		wr(8'h10, 32'h0000_00FF);
		rd_chk(8'h10, 32'h0);
		wr(LTIS_IDX_STAT, 32'h0000_0072);
		rd_chk(LTIS_IDX_STAT, 32'h0);
		set_thr(48'hC3B2A1_665544, 1'b0);
		set_thr(48'hC3B2A1_665544, 1'b1);
		set_thr({24'h000200, 24'h000100}, 1'b0);
		wr(LTIS_IDX_CTRL, 32'h0000_0211);
		// Two low, one break, two low: not yet enough
		meas.sample(LO);
		meas.sample(LO);
		meas.sample(MID);
		meas.sample(LO);
		meas.sample(LO);
		rd_chk(LTIS_IDX_STAT, 32'h0);
		meas.sample(LO);
		rd_chk(LTIS_IDX_STAT, 32'h08);
		rd_chk(LTIS_IDX_CROSS, 32'h1);
		check({31'h0, irq_pin}, 32'h1);
		wr(LTIS_IDX_STAT, 32'h0000_0077);
		rd_chk(LTIS_IDX_STAT, 32'h08);
		wr(LTIS_IDX_STAT, 32'h0000_0008);
		rd_chk(LTIS_IDX_STAT, 32'h0);
		rd_chk(LTIS_IDX_CROSS, 32'h0);
		check({31'h0, irq_pin}, 32'h0);
		repeat (3) meas.sample(HI);
		rd_chk(LTIS_IDX_STAT, 32'h08);
		rd_chk(LTIS_IDX_CROSS, 32'h2);
		wr(LTIS_IDX_STAT, 32'h0000_0008);
		meas.pulse(1'b1, 1'b0);
		rd_chk(LTIS_IDX_STAT, 32'h80);
		check({31'h0, irq_pin}, 32'h1);
		wr(LTIS_IDX_STAT, 32'h0000_0080);
		rd_chk(LTIS_IDX_STAT, 32'h0);
		check({31'h0, irq_pin}, 32'h0);
		meas.level(1'b1);
		rd_chk(LTIS_IDX_STAT, 32'h04);
		wr(LTIS_IDX_STAT, 32'h0000_0004);
		rd_chk(LTIS_IDX_STAT, 32'h04);
		meas.level(1'b0);
		rd_chk(LTIS_IDX_STAT, 32'h0);
		meas.pulse(1'b0, 1'b1);
		rd_chk(LTIS_IDX_STAT, 32'h0);
		wr(LTIS_IDX_CTRL, 32'h0000_0002);
		meas.pulse(1'b0, 1'b1);
		rd_chk(LTIS_IDX_STAT, 32'h01);
		// Out-of-range channel falls back to channel 0; persistence 0 fires at once
		wr(LTIS_IDX_CTRL, 32'h0000_0031);
		meas.sample(HI);
		rd_chk(LTIS_IDX_STAT, 32'h09);
		rd_chk(LTIS_IDX_CROSS, 32'h1);
		check({31'h0, hresp}, 32'h0);
		tally_and_finish;
	end
endmodule : light_threshold_interrupt_status_test

// >>> ltis_meas_model.sv
// Model of the measurement front end that feeds the status block
`timescale 1ns/1ps
module ltis_meas_model (
	// Clock
	input  wire logic        clk_sys,
	// Measurement outputs
	output logic             sample_vld,
	output logic [71:0]      accum_data,
	output logic             saturation_evt,
	output logic             fifo_level_met,
	output logic             system_evt
);
	initial
	begin
		sample_vld     = 1'b0;
		accum_data     = 72'h0;
		saturation_evt = 1'b0;
		fifo_level_met = 1'b0;
		system_evt     = 1'b0;
	end
	// One sample pulse; data is scrambled once the pulse has gone
	task automatic sample(input logic [71:0] d);
		@(posedge clk_sys);
		sample_vld <= 1'b1;
		accum_data <= d;
		@(posedge clk_sys);
		sample_vld <= 1'b0;
		accum_data <= ~d;
	endtask : sample
	task automatic pulse(input logic s, input logic y);
		@(posedge clk_sys);
		saturation_evt <= s;
		system_evt     <= y;
		@(posedge clk_sys);
		saturation_evt <= 1'b0;
		system_evt     <= 1'b0;
	endtask : pulse
	task automatic level(input logic v);
		@(posedge clk_sys);
		fifo_level_met <= v;
	endtask : level
endmodule : ltis_meas_model

// >>> ltis_persist.sv
// Persistence filter: counts consecutive samples meeting a condition
`timescale 1ns/1ps
module ltis_persist #(
	parameter int CW = 4
) (
	// Clock and reset
	input  wire logic          clk_sys,
	input  wire logic          rst_b,
	// Sample stream
	input  wire logic          sample_vld,
	input  wire logic          cond,
	input  wire logic [CW-1:0] persist,
	// Result pulse
	output logic               hit
);
	import ltis_pkg::*;
	logic [CW:0] cnt_ff;
	logic [CW:0] nxt_cnt;
	logic        nxt_hit;

	always_comb
	begin
		nxt_cnt = cnt_ff;
		nxt_hit = 1'b0;
		if (sample_vld)
		begin
			if (!cond)
				nxt_cnt = '0;
			else
			begin
				if (cnt_ff <= {1'b0, persist})
					nxt_cnt = cnt_ff + 1'b1;
				// Fire on every qualifying sample once the run reaches persist+1
				nxt_hit = (cnt_ff >= {1'b0, persist});
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			cnt_ff <= '0;
		else
			cnt_ff <= nxt_cnt;
	end

	assign hit = nxt_hit;
endmodule : ltis_persist

// >>> ltis_pkg.sv
// Package: register map, field positions and constants of the light threshold interrupt block
package ltis_pkg;
	// ----------------------------------------
	// Register word indices; the bus byte address is four times the index
	// ----------------------------------------
	localparam logic [7:0] LTIS_IDX_LOW0  = 8'h8A;
	localparam logic [7:0] LTIS_IDX_LOW1  = 8'h8B;
	localparam logic [7:0] LTIS_IDX_LOW2  = 8'h8C;
	localparam logic [7:0] LTIS_IDX_HIGH0 = 8'h8D;
	localparam logic [7:0] LTIS_IDX_HIGH1 = 8'h8E;
	localparam logic [7:0] LTIS_IDX_HIGH2 = 8'h8F;
	localparam logic [7:0] LTIS_IDX_AUX   = 8'h90;
	localparam logic [7:0] LTIS_IDX_REV   = 8'h91;
	localparam logic [7:0] LTIS_IDX_DEV   = 8'h92;
	localparam logic [7:0] LTIS_IDX_STAT  = 8'h93;
	localparam logic [7:0] LTIS_IDX_CTRL  = 8'hA0;
	localparam logic [7:0] LTIS_IDX_CROSS = 8'hA1;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int LTIS_BIT_SAT  = 7;
	localparam int LTIS_BIT_LITE = 3;
	localparam int LTIS_BIT_FIFO = 2;
	localparam int LTIS_BIT_SYS  = 0;
	localparam int LTIS_CTRL_LEN = 0;
	localparam int LTIS_CTRL_SEN = 1;
	localparam int LTIS_CTRL_CH  = 4;
	localparam int LTIS_CTRL_PER = 8;
	localparam logic [7:0] LTIS_STAT_MASK = 8'h8D;
	// ----------------------------------------
	// Reset values; identity codes are arbitrary
	// ----------------------------------------
	localparam logic [23:0] LTIS_THR_RST  = 24'h000000;
	localparam logic [7:0]  LTIS_STAT_RST = 8'h00;
	localparam logic [3:0]  LTIS_AUX_CODE = 4'hA;
	localparam logic [7:0]  LTIS_REV_CODE = 8'h42;
	localparam logic [7:0]  LTIS_DEV_CODE = 8'hC3;
	localparam logic [1:0]  LTIS_HTRANS_NONSEQ = 2'h2;
endpackage : ltis_pkg

// >>> ltis_top.sv
// Light threshold interrupt status block with AHB-Lite register slave
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ltis_top #(
	parameter int NCH = 3,
	parameter int PW  = 4
) (
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst_b,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic [31:0]            hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	// Measurement side (same clock)
	input  wire logic              sample_vld,
	input  wire logic [NCH*24-1:0] accum_data,
	input  wire logic              saturation_evt,
	input  wire logic              fifo_level_met,
	input  wire logic              system_evt,
	// Interrupt pin
	output logic                   irq_pin
);
	import ltis_pkg::*;

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [23:0]  low_thr_ff, nxt_low_thr;
	logic [23:0]  high_thr_ff, nxt_high_thr;
	logic [7:0]   stat_ff, nxt_stat;
	logic [1:0]   cross_ff, nxt_cross;
	logic         len_ff, nxt_len;
	logic         sen_ff, nxt_sen;
	logic [1:0]   chsel_ff, nxt_chsel;
	logic [PW-1:0] pers_ff, nxt_pers;
	logic         wpend_ff, nxt_wpend;
	logic [7:0]   widx_ff, nxt_widx;
	logic [31:0]  rdata_ff, nxt_rdata;

	logic         acc;
	logic [7:0]   aidx;
	logic [7:0]   wb;
	logic [23:0]  sel_data;
	logic         low_hit, high_hit;

	// ----------------------------------------
	// Bus address phase
	// ----------------------------------------
	// Word index = byte address / 4
	assign acc  = hsel && hready && (htrans == LTIS_HTRANS_NONSEQ || htrans == 2'h3);
	assign aidx = haddr[9:2];
	assign wb   = hwdata[7:0];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_ff;

	// ----------------------------------------
	// Channel select and comparison
	// ----------------------------------------
	always_comb
	begin
		sel_data = accum_data[23:0];
		for (int i = 0; i < NCH; i++)
			if (chsel_ff == i[1:0])
				sel_data = accum_data[i*24 +: 24];
	end

	ltis_persist #(.CW(PW)) u_low (
		.clk_sys    (clk_sys),
		.rst_b      (rst_b),
		.sample_vld (sample_vld && len_ff),
		.cond       (sel_data < low_thr_ff),
		.persist    (pers_ff),
		.hit        (low_hit)
	);

	ltis_persist #(.CW(PW)) u_high (
		.clk_sys    (clk_sys),
		.rst_b      (rst_b),
		.sample_vld (sample_vld && len_ff),
		.cond       (sel_data > high_thr_ff),
		.persist    (pers_ff),
		.hit        (high_hit)
	);

	// ----------------------------------------
	// Register updates
	// ----------------------------------------
	always_comb
	begin
		nxt_low_thr  = low_thr_ff;
		nxt_high_thr = high_thr_ff;
		nxt_stat     = stat_ff;
		nxt_cross    = cross_ff;
		nxt_len      = len_ff;
		nxt_sen      = sen_ff;
		nxt_chsel    = chsel_ff;
		nxt_pers     = pers_ff;
		nxt_wpend    = acc && hwrite;
		nxt_widx     = acc ? aidx : widx_ff;
		nxt_rdata    = 32'h00000000;
		// Data phase of a write
		if (wpend_ff)
		begin
			if (widx_ff == LTIS_IDX_LOW0)
				nxt_low_thr[7:0] = wb;
			else if (widx_ff == LTIS_IDX_LOW1)
				nxt_low_thr[15:8] = wb;
			else if (widx_ff == LTIS_IDX_LOW2)
				nxt_low_thr[23:16] = wb;
			else if (widx_ff == LTIS_IDX_HIGH0)
				nxt_high_thr[7:0] = wb;
			else if (widx_ff == LTIS_IDX_HIGH1)
				nxt_high_thr[15:8] = wb;
			else if (widx_ff == LTIS_IDX_HIGH2)
				nxt_high_thr[23:16] = wb;
			else if (widx_ff == LTIS_IDX_STAT)
			begin
				// Write one to clear; zero leaves the bit alone
				nxt_stat = stat_ff & ~(wb & LTIS_STAT_MASK);
				if (wb[LTIS_BIT_LITE])
					nxt_cross = 2'b00;
			end
			else if (widx_ff == LTIS_IDX_CTRL)
			begin
				nxt_len   = hwdata[LTIS_CTRL_LEN];
				nxt_sen   = hwdata[LTIS_CTRL_SEN];
				nxt_chsel = hwdata[LTIS_CTRL_CH +: 2];
				nxt_pers  = hwdata[LTIS_CTRL_PER +: PW];
			end
		end
		// Hardware sets win over a simultaneous clear
		if (saturation_evt)
			nxt_stat[LTIS_BIT_SAT] = 1'b1;
		if (low_hit)
		begin
			nxt_stat[LTIS_BIT_LITE] = 1'b1;
			nxt_cross[0] = 1'b1;
		end
		if (high_hit)
		begin
			nxt_stat[LTIS_BIT_LITE] = 1'b1;
			nxt_cross[1] = 1'b1;
		end
		// FIFO flag tracks the level condition
		if (fifo_level_met)
			nxt_stat[LTIS_BIT_FIFO] = 1'b1;
		else
			nxt_stat[LTIS_BIT_FIFO] = 1'b0;
		if (system_evt && sen_ff)
			nxt_stat[LTIS_BIT_SYS] = 1'b1;
		// Read data for the following data phase
		if (acc && !hwrite)
		begin
			if (aidx == LTIS_IDX_LOW0)
				nxt_rdata[7:0] = low_thr_ff[7:0];
			else if (aidx == LTIS_IDX_LOW1)
				nxt_rdata[7:0] = low_thr_ff[15:8];
			else if (aidx == LTIS_IDX_LOW2)
				nxt_rdata[7:0] = low_thr_ff[23:16];
			else if (aidx == LTIS_IDX_HIGH0)
				nxt_rdata[7:0] = high_thr_ff[7:0];
			else if (aidx == LTIS_IDX_HIGH1)
				nxt_rdata[7:0] = high_thr_ff[15:8];
			else if (aidx == LTIS_IDX_HIGH2)
				nxt_rdata[7:0] = high_thr_ff[23:16];
			else if (aidx == LTIS_IDX_AUX)
				nxt_rdata[3:0] = LTIS_AUX_CODE;
			else if (aidx == LTIS_IDX_REV)
				nxt_rdata[7:0] = LTIS_REV_CODE;
			else if (aidx == LTIS_IDX_DEV)
				nxt_rdata[7:0] = LTIS_DEV_CODE;
			else if (aidx == LTIS_IDX_STAT)
				nxt_rdata[7:0] = stat_ff & LTIS_STAT_MASK;
			else if (aidx == LTIS_IDX_CTRL)
			begin
				nxt_rdata[LTIS_CTRL_LEN]       = len_ff;
				nxt_rdata[LTIS_CTRL_SEN]       = sen_ff;
				nxt_rdata[LTIS_CTRL_CH +: 2]   = chsel_ff;
				nxt_rdata[LTIS_CTRL_PER +: PW] = pers_ff;
			end
			else if (aidx == LTIS_IDX_CROSS)
				nxt_rdata[1:0] = cross_ff;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			low_thr_ff  <= LTIS_THR_RST;
			high_thr_ff <= LTIS_THR_RST;
			stat_ff     <= LTIS_STAT_RST;
			cross_ff    <= 2'b00;
			len_ff      <= 1'b0;
			sen_ff      <= 1'b0;
			chsel_ff    <= 2'b00;
			pers_ff     <= '0;
			wpend_ff    <= 1'b0;
			widx_ff     <= 8'h00;
			rdata_ff    <= 32'h00000000;
		end
		else
		begin
			low_thr_ff  <= nxt_low_thr;
			high_thr_ff <= nxt_high_thr;
			stat_ff     <= nxt_stat;
			cross_ff    <= nxt_cross;
			len_ff      <= nxt_len;
			sen_ff      <= nxt_sen;
			chsel_ff    <= nxt_chsel;
			pers_ff     <= nxt_pers;
			wpend_ff    <= nxt_wpend;
			widx_ff     <= nxt_widx;
			rdata_ff    <= nxt_rdata;
		end
	end

	// ----------------------------------------
	// Interrupt pin
	// ----------------------------------------
	assign irq_pin = |(stat_ff & LTIS_STAT_MASK);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sat_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		saturation_evt |=> stat_ff[LTIS_BIT_SAT])
		else $error("saturation flag not set");
	low_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		low_hit |=> stat_ff[LTIS_BIT_LITE] && cross_ff[0])
		else $error("low crossing not flagged");
	high_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		high_hit |=> stat_ff[LTIS_BIT_LITE] && cross_ff[1])
		else $error("high crossing not flagged");
	fifo_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		stat_ff[LTIS_BIT_FIFO] == $past(fifo_level_met))
		else $error("fifo flag not following level");
	reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(stat_ff & ~LTIS_STAT_MASK) == 8'h00)
		else $error("reserved status bit set");
	irq_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		((stat_ff & LTIS_STAT_MASK) != 8'h00) |-> irq_pin)
		else $error("pin low with flag set");
	sys_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(!sen_ff && !stat_ff[LTIS_BIT_SYS]) |=> !stat_ff[LTIS_BIT_SYS])
		else $error("system flag set while disabled");
	lite_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wpend_ff && widx_ff == LTIS_IDX_STAT && wb[LTIS_BIT_LITE] && !low_hit && !high_hit)
		|=> !stat_ff[LTIS_BIT_LITE])
		else $error("light flag not cleared");
	id_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(acc && !hwrite && aidx == LTIS_IDX_DEV) |=> hrdata == {24'h000000, LTIS_DEV_CODE})
		else $error("device code wrong");

	// ----------------------------------------
	// Assertions on clears, writes, reads, the system set, gating and the pin
	// ----------------------------------------
	sat_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wpend_ff && widx_ff == LTIS_IDX_STAT && wb[LTIS_BIT_SAT] && !saturation_evt)
		|=> !stat_ff[LTIS_BIT_SAT])
		else $error("saturation flag not cleared");
	cross_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wpend_ff && widx_ff == LTIS_IDX_STAT && wb[LTIS_BIT_LITE] && !low_hit && !high_hit)
		|=> cross_ff == 2'b00)
		else $error("crossing detail not cleared");
	lite_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wpend_ff && widx_ff == LTIS_IDX_STAT && !wb[LTIS_BIT_LITE] && stat_ff[LTIS_BIT_LITE])
		|=> stat_ff[LTIS_BIT_LITE])
		else $error("light flag lost on zero write");
	fifo_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wpend_ff && widx_ff == LTIS_IDX_STAT && wb[LTIS_BIT_FIFO] && !fifo_level_met)
		|=> !stat_ff[LTIS_BIT_FIFO])
		else $error("fifo flag not cleared");
	cross_tie_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(|cross_ff) |-> stat_ff[LTIS_BIT_LITE])
		else $error("crossing detail without light flag");
	light_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!len_ff |-> (!low_hit && !high_hit))
		else $error("crossing while light disabled");
	sys_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(system_evt && sen_ff) |=> stat_ff[LTIS_BIT_SYS])
		else $error("system flag not set");
	irq_low_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(stat_ff == 8'h00) |-> !irq_pin)
		else $error("pin high with no flag set");
	low_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wpend_ff && widx_ff == LTIS_IDX_LOW0) |=> low_thr_ff[7:0] == $past(wb))
		else $error("low threshold byte not written");
	high_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wpend_ff && widx_ff == LTIS_IDX_HIGH2) |=> high_thr_ff[23:16] == $past(wb))
		else $error("high threshold byte not written");
	stat_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(acc && !hwrite && aidx == LTIS_IDX_STAT) |=> (hrdata & 32'hFFFFFF72) == 32'h00000000)
		else $error("reserved status bits read non-zero");
	aux_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(acc && !hwrite && aidx == LTIS_IDX_AUX) |=> hrdata == {28'h0000000, LTIS_AUX_CODE})
		else $error("auxiliary code wrong");
	rev_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(acc && !hwrite && aidx == LTIS_IDX_REV) |=> hrdata == {24'h000000, LTIS_REV_CODE})
		else $error("revision code wrong");
endmodule : ltis_top
